// [verilog/mivc_pkg.sv]
// Constants and types shared by the multilevel interrupt controller files
package mivc_pkg;

  localparam int NUM_SRC = 27;
  localparam int VEC_W = 16;
  localparam int OFS_W = 4;
  localparam int NUM_LVL = 3;

  // Word addresses in program memory
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  localparam logic [15:0] CRYSTAL_FAILURE_VECTOR = 16'h0002;
  localparam logic [15:0] PORT_C_IRQ_BASE = 16'h0004;
  localparam logic [15:0] PORT_R_IRQ_BASE = 16'h0008;
  localparam logic [15:0] DMA_IRQ_BASE = 16'h000C;
  localparam logic [15:0] RTC_IRQ_BASE = 16'h0014;
  localparam logic [15:0] TWO_WIRE_C_IRQ_BASE = 16'h0018;
  localparam logic [15:0] TIMER_C_FIRST_IRQ_BASE = 16'h001C;
  localparam logic [15:0] TIMER_C_SECOND_IRQ_BASE = 16'h0028;
  localparam logic [15:0] SPI_C_VECTOR = 16'h0030;
  localparam logic [15:0] SERIAL_C_FIRST_IRQ_BASE = 16'h0032;
  localparam logic [15:0] SERIAL_C_SECOND_IRQ_BASE = 16'h0038;
  localparam logic [15:0] CIPHER_VECTOR = 16'h003E;
  localparam logic [15:0] NONVOLATILE_IRQ_BASE = 16'h0040;
  localparam logic [15:0] PORT_B_IRQ_BASE = 16'h0044;
  localparam logic [15:0] PORT_E_IRQ_BASE = 16'h0056;
  localparam logic [15:0] TWO_WIRE_E_IRQ_BASE = 16'h005A;
  localparam logic [15:0] TIMER_E_FIRST_IRQ_BASE = 16'h005E;
  localparam logic [15:0] TIMER_E_SECOND_IRQ_BASE = 16'h006A;
  localparam logic [15:0] SERIAL_E_FIRST_IRQ_BASE = 16'h0074;
  localparam logic [15:0] PORT_D_IRQ_BASE = 16'h0080;
  localparam logic [15:0] PORT_A_IRQ_BASE = 16'h0084;
  localparam logic [15:0] COMPARATOR_A_IRQ_BASE = 16'h0088;
  localparam logic [15:0] CONVERTER_A_IRQ_BASE = 16'h008E;
  localparam logic [15:0] TIMER_D_FIRST_IRQ_BASE = 16'h009A;
  localparam logic [15:0] TIMER_D_SECOND_IRQ_BASE = 16'h00A6;
  localparam logic [15:0] SPI_D_VECTOR = 16'h00AE;
  localparam logic [15:0] SERIAL_D_FIRST_IRQ_BASE = 16'h00B0;
  localparam logic [15:0] SERIAL_D_SECOND_IRQ_BASE = 16'h00B6;

  // Default first word of the boot section; depends on memory size
  localparam logic [15:0] BOOT_BASE_DEFAULT = 16'h1000;

  // Source index order follows ascending vector address
  localparam logic [15:0] SRC_BASE [NUM_SRC] = '{
    PORT_C_IRQ_BASE, PORT_R_IRQ_BASE, DMA_IRQ_BASE, RTC_IRQ_BASE, TWO_WIRE_C_IRQ_BASE,
    TIMER_C_FIRST_IRQ_BASE, TIMER_C_SECOND_IRQ_BASE, SPI_C_VECTOR, SERIAL_C_FIRST_IRQ_BASE,
    SERIAL_C_SECOND_IRQ_BASE, CIPHER_VECTOR, NONVOLATILE_IRQ_BASE, PORT_B_IRQ_BASE,
    PORT_E_IRQ_BASE, TWO_WIRE_E_IRQ_BASE, TIMER_E_FIRST_IRQ_BASE, TIMER_E_SECOND_IRQ_BASE,
    SERIAL_E_FIRST_IRQ_BASE, PORT_D_IRQ_BASE, PORT_A_IRQ_BASE, COMPARATOR_A_IRQ_BASE,
    CONVERTER_A_IRQ_BASE, TIMER_D_FIRST_IRQ_BASE, TIMER_D_SECOND_IRQ_BASE, SPI_D_VECTOR,
    SERIAL_D_FIRST_IRQ_BASE, SERIAL_D_SECOND_IRQ_BASE};

  // Sources with one interrupt only: indices 7, 10 and 24
  localparam logic [NUM_SRC-1:0] SRC_SINGLE = 27'h1000480;

  localparam logic [1:0] LVL_OFF = 2'h0;
  localparam logic [1:0] LVL_LOW = 2'h1;
  localparam logic [1:0] LVL_MED = 2'h2;
  localparam logic [1:0] LVL_HIGH = 2'h3;

  typedef enum logic [1:0] {
    MIVC_ST_BOOT = 2'h0,
    MIVC_ST_RUN = 2'h1,
    MIVC_ST_HOLD = 2'h3
  } mivc_state_t;

endpackage : mivc_pkg

// [verilog/mivc_arb_if.sv]
// Request and grant bundle between the controller and one level arbiter
`timescale 1ns/1ps
interface mivc_arb_if #(parameter int N = 27) ();
  logic [N-1:0] req;
  logic rotate;
  logic advance;
  logic valid;
  logic [$clog2(N)-1:0] idx;
  modport ctl (output req, output rotate, output advance, input valid, input idx);
  modport arb (input req, input rotate, input advance, output valid, output idx);
endinterface : mivc_arb_if

// [verilog/mivc_level_arb.sv]
// Fixed or rotating arbiter for the requests of one priority level
`timescale 1ns/1ps
module mivc_level_arb #(
  parameter int N = 27
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  mivc_arb_if.arb bus
);

  localparam int IW = $clog2(N);

  logic [IW-1:0] ptr_q;

  // Pointer moves past the served source so it ranks last next time
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ptr_q <= '0;
    end else if (bus.advance) begin
      ptr_q <= (bus.idx == IW'(N - 1)) ? '0 : IW'(bus.idx + 1'b1); // R4
    end
  end

  always_comb begin
    int j;
    logic found;
    j = 0;
    found = 1'b0;
    bus.valid = 1'b0;
    bus.idx = '0;
    for (int k = 0; k < N; k++) begin
      j = bus.rotate ? (int'(ptr_q) + k) % N : k; // R4 R22
      if (!found && bus.req[j]) begin
        found = 1'b1;
        bus.valid = 1'b1;
        bus.idx = IW'(j);
      end
    end
  end

  property p_rr_moves;
    @(posedge clk_i) disable iff (!rst_n_i)
      bus.rotate && bus.advance && ((bus.req & ~(N'(1) << bus.idx)) != '0)
      |=> (bus.req != $past(bus.req)) || !bus.rotate || (bus.idx != $past(bus.idx));
  endproperty
  a_rr_moves: assert property (p_rr_moves) else $error("rotation granted same source twice"); // R4

  property p_fixed_lowest;
    @(posedge clk_i) disable iff (!rst_n_i)
      !bus.rotate && bus.valid |-> (bus.req & ((N'(1) << bus.idx) - N'(1))) == '0;
  endproperty
  a_fixed_lowest: assert property (p_fixed_lowest) else $error("fixed order skipped lower vector"); // R22

endmodule : mivc_level_arb

// [verilog/mivc_ctrl.sv]
// Three-level interrupt controller with vector generation and reset fetch
`timescale 1ns/1ps
// Summary of operation
// [R1] Three levels; each source picks its level
// [R2] Medium request pre-empts running low routine
// [R3] High request pre-empts low or medium routine
// [R4] Low level: fixed or round-robin order
// [R5] Crystal failure raises non-maskable interrupt at 0x002
// [R6] Taken interrupt loads core program counter
// [R7] Vector is peripheral base plus offset
// [R8] All addresses are program word addresses
// [R9] Relocation moves vector table to boot
// [R10] Reset vector 0x000, optionally boot start
// [R11] Fetch starts at selected reset vector
// [R12] Single-interrupt entries are complete vectors
// [R13] Port C, R, B bases
// [R14] Port E, D, A bases
// [R15] DMA, real-time counter, non-volatile bases
// [R16] SPI C, cipher, SPI D single vectors
// [R17] Port C timer bases
// [R18] Port E and D timer bases
// [R19] Serial unit bases
// [R20] Two-wire interface bases
// [R21] Comparator and converter bases on port A
// [R22] Fixed order: lowest vector address first
// [R23] No same-level pre-emption; NMI beats all
module mivc_ctrl #(
  parameter logic [15:0] BOOT_BASE = mivc_pkg::BOOT_BASE_DEFAULT
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [mivc_pkg::NUM_SRC-1:0] irq_req_i,
  input wire logic [2*mivc_pkg::NUM_SRC-1:0] irq_level_i,
  input wire logic [mivc_pkg::OFS_W*mivc_pkg::NUM_SRC-1:0] irq_offset_i,
  input wire logic [2:0] level_enable_i,
  input wire logic round_robin_i,
  input wire logic vector_relocate_i,
  input wire logic reset_relocate_i,
  input wire logic xtal_fail_i,
  input wire logic reti_i,
  output logic fetch_start_o,
  output logic pc_load_o,
  output logic [mivc_pkg::VEC_W-1:0] pc_vector_o,
  output logic [mivc_pkg::NUM_SRC-1:0] irq_ack_o,
  output logic nmi_ack_o,
  output logic [1:0] taken_level_o,
  output logic [2:0] active_level_o,
  output logic nmi_active_o,
  output logic [2:0] level_pending_o
);

  localparam int NS = mivc_pkg::NUM_SRC;
  localparam int IW = $clog2(mivc_pkg::NUM_SRC);
  localparam int VW = mivc_pkg::VEC_W;
  localparam int OW = mivc_pkg::OFS_W;

  logic rst_meta_q;
  logic rst_sync_q;
  mivc_pkg::mivc_state_t state_q;
  mivc_pkg::mivc_state_t state_d;
  logic [2:0] active_q;
  logic nmi_active_q;
  logic fetch_start_q;
  logic pc_load_q;
  logic [VW-1:0] pc_vector_q;
  logic [NS-1:0] irq_ack_q;
  logic nmi_ack_q;
  logic [1:0] taken_level_q;
  logic [IW-1:0] take_idx_q;
  logic [2:0] level_pending_q;
  logic [2:0] lvl_valid;
  logic [IW-1:0] lvl_idx [3];
  logic [2:0] lvl_take;
  logic take_nmi;
  logic take_any;
  logic [IW-1:0] sel_idx;
  logic [1:0] sel_level;
  logic [OW-1:0] sel_ofs;
  logic [VW-1:0] sel_vec;
  logic [VW-1:0] table_base;
  logic [VW-1:0] reset_vec;

  // Release of the external reset is resynchronised to the core clock
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // One arbiter per level; only the low level may rotate
  for (genvar l = 0; l < 3; l++) begin : g_lvl
    mivc_arb_if #(.N(NS)) arb_bus ();
    always_comb begin
      for (int i = 0; i < NS; i++) begin
        arb_bus.req[i] = irq_req_i[i] && (irq_level_i[2*i +: 2] == 2'(l + 1)) && level_enable_i[l]; // R1
      end
    end
    assign arb_bus.rotate = (l == 0) ? round_robin_i : 1'b0; // R4
    assign arb_bus.advance = lvl_take[l];
    assign lvl_valid[l] = arb_bus.valid;
    assign lvl_idx[l] = arb_bus.idx;
    mivc_level_arb #(.N(NS)) u_arb (
      .clk_i(clk_sys_i),
      .rst_n_i(rst_sync_q),
      .bus(arb_bus.arb)
    );
  end

  // Level choice against the routines already running
  always_comb begin
    take_nmi = 1'b0;
    lvl_take = 3'h0;
    if (state_q == mivc_pkg::MIVC_ST_RUN) begin
      if (xtal_fail_i && !nmi_active_q) begin
        take_nmi = 1'b1; // R5 R23
      end else if (!nmi_active_q) begin
        if (lvl_valid[2] && !active_q[2]) begin
          lvl_take[2] = 1'b1; // R3
        end else if (lvl_valid[1] && (active_q[2:1] == 2'h0)) begin
          lvl_take[1] = 1'b1; // R2
        end else if (lvl_valid[0] && (active_q == 3'h0)) begin
          lvl_take[0] = 1'b1; // R23
        end
      end
    end
    take_any = take_nmi || (lvl_take != 3'h0);
  end

  always_comb begin
    sel_idx = lvl_idx[0];
    sel_level = mivc_pkg::LVL_LOW;
    if (lvl_take[2]) begin
      sel_idx = lvl_idx[2];
      sel_level = mivc_pkg::LVL_HIGH;
    end else if (lvl_take[1]) begin
      sel_idx = lvl_idx[1];
      sel_level = mivc_pkg::LVL_MED;
    end
  end

  // Word-addressed vector: table base, then peripheral base, then offset
  assign table_base = vector_relocate_i ? BOOT_BASE : '0; // R8 R9
  assign sel_ofs = mivc_pkg::SRC_SINGLE[sel_idx] ? '0 : irq_offset_i[OW*sel_idx +: OW]; // R12
  always_comb begin
    if (take_nmi) begin
      sel_vec = VW'(table_base + mivc_pkg::CRYSTAL_FAILURE_VECTOR); // R5
    end else begin
      sel_vec = VW'(table_base + mivc_pkg::SRC_BASE[sel_idx] // R13 R14 R15 R16 R17 R18 R19 R20 R21
        + {{(VW-OW){1'b0}}, sel_ofs}); // R7
    end
  end
  assign reset_vec = reset_relocate_i ? BOOT_BASE : mivc_pkg::RESET_VECTOR; // R10

  // Hold state gives the peripheral a cycle to drop its request after the ack
  always_comb begin
    state_d = state_q;
    case (state_q)
      mivc_pkg::MIVC_ST_BOOT: begin
        state_d = mivc_pkg::MIVC_ST_RUN;
      end
      mivc_pkg::MIVC_ST_RUN: begin
        if (take_any) begin
          state_d = mivc_pkg::MIVC_ST_HOLD;
        end
      end
      mivc_pkg::MIVC_ST_HOLD: begin
        state_d = mivc_pkg::MIVC_ST_RUN;
      end
      default: begin
        state_d = mivc_pkg::MIVC_ST_BOOT;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      state_q <= mivc_pkg::MIVC_ST_BOOT;
    end else begin
      state_q <= state_d;
    end
  end

  // Program counter loads for reset fetch and for taken interrupts
  always_ff @(posedge clk_sys_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      fetch_start_q <= 1'b0;
      pc_load_q <= 1'b0;
      pc_vector_q <= '0;
      irq_ack_q <= '0;
      nmi_ack_q <= 1'b0;
      taken_level_q <= mivc_pkg::LVL_OFF;
      take_idx_q <= '0;
    end else begin
      fetch_start_q <= 1'b0;
      pc_load_q <= 1'b0;
      irq_ack_q <= '0;
      nmi_ack_q <= 1'b0;
      if (state_q == mivc_pkg::MIVC_ST_BOOT) begin
        fetch_start_q <= 1'b1; // R11
        pc_vector_q <= reset_vec; // R10
      end else if (take_any) begin
        pc_load_q <= 1'b1; // R6
        pc_vector_q <= sel_vec; // R6
        nmi_ack_q <= take_nmi;
        if (!take_nmi) begin
          irq_ack_q <= NS'(1) << sel_idx;
          taken_level_q <= sel_level;
          take_idx_q <= sel_idx;
        end else begin
          taken_level_q <= mivc_pkg::LVL_OFF;
        end
      end
    end
  end

  // Return closes the innermost routine; a new entry in the same cycle still sets
  always_ff @(posedge clk_sys_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      active_q <= 3'h0;
    end else begin
      for (int l = 0; l < 3; l++) begin
        if (lvl_take[l]) begin
          active_q[l] <= 1'b1; // R2 R3
        end else if (reti_i && !nmi_active_q && (active_q >> l) == 3'h1) begin
          active_q[l] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      nmi_active_q <= 1'b0;
    end else if (take_nmi) begin
      nmi_active_q <= 1'b1; // R5
    end else if (reti_i) begin
      nmi_active_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      level_pending_q <= 3'h0;
    end else begin
      level_pending_q <= lvl_valid;
    end
  end

  assign fetch_start_o = fetch_start_q;
  assign pc_load_o = pc_load_q;
  assign pc_vector_o = pc_vector_q;
  assign irq_ack_o = irq_ack_q;
  assign nmi_ack_o = nmi_ack_q;
  assign taken_level_o = taken_level_q;
  assign active_level_o = active_q;
  assign nmi_active_o = nmi_active_q;
  assign level_pending_o = level_pending_q;

  property p_reset_fetch;
    @(posedge clk_sys_i) disable iff (!rst_sync_q)
      $rose(rst_sync_q) |-> ##1 fetch_start_o;
  endproperty
  a_reset_fetch: assert property (p_reset_fetch) else $error("no fetch after reset release"); // R11

  property p_reset_vec;
    @(posedge clk_sys_i) disable iff (!rst_sync_q)
      fetch_start_o |-> pc_vector_o == ($past(reset_relocate_i) ? BOOT_BASE : mivc_pkg::RESET_VECTOR);
  endproperty
  a_reset_vec: assert property (p_reset_vec) else $error("wrong reset vector"); // R10

  property p_nmi_vec;
    @(posedge clk_sys_i) disable iff (!rst_sync_q)
      nmi_ack_o && !$past(vector_relocate_i) |-> pc_load_o && pc_vector_o == mivc_pkg::CRYSTAL_FAILURE_VECTOR;
  endproperty
  a_nmi_vec: assert property (p_nmi_vec) else $error("crystal failure vector wrong"); // R5

  property p_nmi_wins;
    @(posedge clk_sys_i) disable iff (!rst_sync_q)
      $past(xtal_fail_i && !nmi_active_q && state_q == mivc_pkg::MIVC_ST_RUN) |-> nmi_ack_o && irq_ack_o == '0;
  endproperty
  a_nmi_wins: assert property (p_nmi_wins) else $error("non-maskable request not taken"); // R23

  property p_med_preempt;
    @(posedge clk_sys_i) disable iff (!rst_sync_q)
      pc_load_o && taken_level_o == mivc_pkg::LVL_MED && !nmi_ack_o |-> $past(active_q[2:1]) == 2'h0;
  endproperty
  a_med_preempt: assert property (p_med_preempt) else $error("medium entered over medium or high"); // R2

  property p_high_preempt;
    @(posedge clk_sys_i) disable iff (!rst_sync_q)
      pc_load_o && taken_level_o == mivc_pkg::LVL_HIGH && !nmi_ack_o |-> !$past(active_q[2]) ##1 active_q[2];
  endproperty
  a_high_preempt: assert property (p_high_preempt) else $error("high entry wrong"); // R3

  property p_low_blocked;
    @(posedge clk_sys_i) disable iff (!rst_sync_q)
      pc_load_o && taken_level_o == mivc_pkg::LVL_LOW && !nmi_ack_o |-> $past(active_q) == 3'h0;
  endproperty
  a_low_blocked: assert property (p_low_blocked) else $error("low routine pre-empted a routine"); // R23

  property p_ack_loads;
    @(posedge clk_sys_i) disable iff (!rst_sync_q)
      irq_ack_o != '0 |-> pc_load_o && $onehot(irq_ack_o) ##1 !pc_load_o;
  endproperty
  a_ack_loads: assert property (p_ack_loads) else $error("ack without single program counter load"); // R6

  property p_single_vec;
    @(posedge clk_sys_i) disable iff (!rst_sync_q)
      irq_ack_o != '0 && mivc_pkg::SRC_SINGLE[take_idx_q] && !$past(vector_relocate_i)
      |-> pc_vector_o == mivc_pkg::SRC_BASE[take_idx_q];
  endproperty
  a_single_vec: assert property (p_single_vec) else $error("offset added to single vector"); // R12

  property p_relocate;
    @(posedge clk_sys_i) disable iff (!rst_sync_q)
      pc_load_o && $past(vector_relocate_i) |-> pc_vector_o >= BOOT_BASE;
  endproperty
  a_relocate: assert property (p_relocate) else $error("relocated vector below boot section"); // R9

  property p_nmi_blocks;
    @(posedge clk_sys_i) disable iff (!rst_sync_q)
      $past(nmi_active_o) |-> !pc_load_o;
  endproperty
  a_nmi_blocks: assert property (p_nmi_blocks) else $error("load while crystal failure routine ran"); // R23

  property p_low_enabled;
    @(posedge clk_sys_i) disable iff (!rst_sync_q)
      pc_load_o && !nmi_ack_o && taken_level_o == mivc_pkg::LVL_LOW |-> $past(level_enable_i[0]);
  endproperty
  a_low_enabled: assert property (p_low_enabled) else $error("low source taken while low level disabled"); // R1

  property p_pending_enabled;
    @(posedge clk_sys_i) disable iff (!rst_sync_q)
      level_pending_o[0] |-> $past(level_enable_i[0]);
  endproperty
  a_pending_enabled: assert property (p_pending_enabled) else $error("low pending while low level disabled"); // R1

  property p_load_gap;
    @(posedge clk_sys_i) disable iff (!rst_sync_q)
      pc_load_o |=> !pc_load_o && !fetch_start_o;
  endproperty
  a_load_gap: assert property (p_load_gap) else $error("program counter loaded twice in a row"); // R6

  property p_fetch_pulse;
    @(posedge clk_sys_i) disable iff (!rst_sync_q)
      fetch_start_o |=> !fetch_start_o;
  endproperty
  a_fetch_pulse: assert property (p_fetch_pulse) else $error("fetch start longer than one cycle"); // R11

endmodule : mivc_ctrl

// [test/mivc_periph_model.sv]
// Peripheral and oscillator side: requests held until the controller acknowledges them
`timescale 1ns/1ps
module mivc_periph_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [mivc_pkg::NUM_SRC-1:0] raise_i,
  input wire logic raise_xtal_i,
  input wire logic [mivc_pkg::NUM_SRC-1:0] irq_ack_i,
  input wire logic nmi_ack_i,
  output logic [mivc_pkg::NUM_SRC-1:0] irq_req_o,
  output logic xtal_fail_o
);
  // Drop one cycle after ack, so a served source is not taken twice
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_req_o <= '0;
    end else begin
      irq_req_o <= (irq_req_o & ~irq_ack_i) | raise_i;
    end
  end

  // Failure flag stays up until the core has taken it
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      xtal_fail_o <= 1'b0;
    end else begin
      xtal_fail_o <= (xtal_fail_o & ~nmi_ack_i) | raise_xtal_i;
    end
  end
endmodule : mivc_periph_model

// [test/testbench.sv]
// Self-checking bench for the three-level interrupt controller
`timescale 1ns/1ps
module testbench;
  localparam int N = mivc_pkg::NUM_SRC;
  localparam logic [15:0] BOOT = 16'h0800;
  // Own copy of the table, so a wrong package constant shows up
  localparam logic [15:0] BASE [N] = '{16'h0004, 16'h0008, 16'h000C, 16'h0014, 16'h0018, 16'h001C, 16'h0028,
    16'h0030, 16'h0032, 16'h0038, 16'h003E, 16'h0040, 16'h0044, 16'h0056, 16'h005A, 16'h005E, 16'h006A,
    16'h0074, 16'h0080, 16'h0084, 16'h0088, 16'h008E, 16'h009A, 16'h00A6, 16'h00AE, 16'h00B0, 16'h00B6};
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [N-1:0] raise = 27'h0000000;
  logic raise_x = 1'b0;
  logic [2*N-1:0] lvl = {27{2'h1}};
  logic [4*N-1:0] ofs;
  logic [2:0] en = 3'h0;
  logic rr = 1'b0;
  logic vrel = 1'b0;
  logic rrel = 1'b0;
  logic reti = 1'b0;
  logic [N-1:0] req;
  logic [N-1:0] ack;
  logic xtal;
  logic nack;
  logic fetch;
  logic load;
  logic [15:0] pcv;
  logic [1:0] tlv;
  logic [2:0] act;
  logic nact;
  logic [2:0] pend;
  int mismatches = 0;
  int checked = 0;

  initial begin
    forever #20 clk_sys = ~clk_sys;
  end

  mivc_periph_model periph (.clk_i(clk_sys), .rst_n_i(rst_n), .raise_i(raise), .raise_xtal_i(raise_x),
    .irq_ack_i(ack), .nmi_ack_i(nack), .irq_req_o(req), .xtal_fail_o(xtal));

  mivc_ctrl #(.BOOT_BASE(BOOT)) dut (.clk_sys_i(clk_sys), .rst_n_i(rst_n), .irq_req_i(req), .irq_level_i(lvl),
    .irq_offset_i(ofs), .level_enable_i(en), .round_robin_i(rr), .vector_relocate_i(vrel),
    .reset_relocate_i(rrel), .xtal_fail_i(xtal), .reti_i(reti), .fetch_start_o(fetch), .pc_load_o(load),
    .pc_vector_o(pcv), .irq_ack_o(ack), .nmi_ack_o(nack), .taken_level_o(tlv), .active_level_o(act),
    .nmi_active_o(nact), .level_pending_o(pend));

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  function automatic logic [15:0] vexp(input int i);
    logic single;
    single = (i == 7) || (i == 10) || (i == 24);
    return (vrel ? BOOT : 16'h0000) + BASE[i] + (single ? 16'h0000 : {12'h000, ofs[4*i+:4]});
  endfunction : vexp

  task automatic do_reset(input logic [15:0] exp);
    int n;
    n = 0;
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    #1;
    while (fetch !== 1'b1 && n < 8) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk("fetch start", 32'h1, {31'h0, fetch});
    chk("reset vector", {16'h0, exp}, {16'h0, pcv});
  endtask : do_reset

  // One-cycle raise; the model holds the request until ack
  task automatic pulse(input logic [N-1:0] m, input logic x);
    @(posedge clk_sys);
    raise <= m;
    raise_x <= x;
    @(posedge clk_sys);
    raise <= 27'h0000000;
    raise_x <= 1'b0;
    #1;
  endtask : pulse

  task automatic take(input int src, input logic [15:0] vec, input logic [1:0] lv);
    int n;
    n = 0;
    while (load !== 1'b1 && n < 12) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk("pc load", 32'h1, {31'h0, load});
    chk("pc vector", {16'h0, vec}, {16'h0, pcv});
    chk("source ack", src < 0 ? 32'h0 : 32'h1 << src, {5'h0, ack});
    chk("nmi ack", {31'h0, src < 0}, {31'h0, nack});
    chk("taken level", {30'h0, lv}, {30'h0, tlv});
    @(posedge clk_sys);
    #1;
  endtask : take

  // Nothing may be taken for n cycles
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      #1;
      chk("no load", 32'h0, {31'h0, load});
    end
  endtask : idle

  task automatic ret;
    @(posedge clk_sys);
    reti <= 1'b1;
    @(posedge clk_sys);
    reti <= 1'b0;
    #1;
  endtask : ret

  initial begin
    for (int i = 0; i < N; i++) begin
      ofs[4*i+:4] = 4'(i) ^ 4'hA;
    end
    do_reset(16'h0000);
    @(posedge clk_sys);
    en <= 3'h7;
    for (int r = 0; r < 2; r++) begin
      @(posedge clk_sys);
      vrel <= r[0];
      for (int i = 0; i < N; i++) begin
        pulse(27'h1 << i, 1'b0);
        take(i, vexp(i), 2'h1);
        ret();
      end
    end
    pulse(27'h0000000, 1'b1);
    take(-1, BOOT + 16'h0002, 2'h0);
    ret();
    $display("test vectors done");

    @(posedge clk_sys);
    vrel <= 1'b0;
    lvl[2*11+:2] <= mivc_pkg::LVL_MED;
    lvl[2*0+:2] <= mivc_pkg::LVL_HIGH;
    lvl[2*1+:2] <= mivc_pkg::LVL_HIGH;
    pulse(27'h0000008, 1'b0);
    take(3, vexp(3), 2'h1);
    pulse(27'h0000800, 1'b0);
    take(11, vexp(11), 2'h2);
    pulse(27'h0000001, 1'b0);
    take(0, vexp(0), 2'h3);
    chk("active levels", 32'h7, {29'h0, act});
    pulse(27'h0000002, 1'b0);
    idle(6);
    chk("level pending", 32'h4, {29'h0, pend});
    ret();
    take(1, vexp(1), 2'h3);
    repeat (3) ret();
    @(posedge clk_sys);
    en <= 3'h0;
    lvl[2*2+:2] <= mivc_pkg::LVL_HIGH;
    pulse(27'h0000000, 1'b1);
    take(-1, 16'h0002, 2'h0);
    chk("nmi active", 32'h1, {31'h0, nact});
    @(posedge clk_sys);
    en <= 3'h7;
    pulse(27'h0000004, 1'b0);
    idle(5);
    ret();
    take(2, vexp(2), 2'h3);
    ret();
    $display("test preemption done");

    @(posedge clk_sys);
    en <= 3'h6;
    lvl[2*2+:2] <= mivc_pkg::LVL_LOW;
    pulse(27'h0100024, 1'b0);
    idle(4);
    chk("level pending", 32'h0, {29'h0, pend});
    @(posedge clk_sys);
    en <= 3'h7;
    take(2, vexp(2), 2'h1);
    ret();
    take(5, vexp(5), 2'h1);
    ret();
    take(20, vexp(20), 2'h1);
    ret();
    @(posedge clk_sys);
    rr <= 1'b1;
    pulse(27'h0000004, 1'b0);
    take(2, vexp(2), 2'h1);
    ret();
    pulse(27'h0000024, 1'b0);
    take(5, vexp(5), 2'h1);
    ret();
    take(2, vexp(2), 2'h1);
    ret();
    $display("test low order done");

    @(posedge clk_sys);
    rrel <= 1'b1;
    do_reset(BOOT);
    $display("test reset relocate done");
    finish_test();
  end

  // Whole run is about 450 cycles; this cuts a hang short
  initial begin
    repeat (6000) @(posedge clk_sys);
    mismatches++;
    $display("ERROR watchdog expected end of tests seen timeout");
    finish_test();
  end
endmodule : testbench
